// ### hw/acc_core_exec.sv
// execution core for the arithmetic, logic, move and control-flow instruction group
// Function
// - carry-sum adds acc, memory and carry; to acc or memory; five flags
// - plain sum ignores carry; memory or immediate; to acc or memory; five flags
// - bitwise and with memory or immediate; to acc or memory; zero flag only
// - bitwise or with memory or immediate; to acc or memory; zero flag only
// - call pushes pc plus one, loads target, two cycles, no flags
// - byte clear writes zero to memory, no flags
// - bit clear zeroes one selected bit, keeps others, no flags
// - watchdog restart clears counter, timeout flag and powerdown flag
// - invert memory byte to memory or acc; zero flag only
// - decimal adjust acc by six per nibble into memory; only carry changes
// - count down memory byte to memory or acc; zero flag only
// - count up memory byte to memory or acc; zero flag only
// - power down halts, gates clock, clears watchdog, sets powerdown, clears timeout
// - jump loads target with one dummy cycle, two cycles, no flags
// - copies between memory, immediate and acc change no flag
// - idle step only advances the program counter
// - subroutine exit pops stack into pc, no flags
// - exit with value pops pc and loads acc with immediate
// - interrupt exit pops pc, sets global enable; pending interrupt served first
module acc_core_exec #(
  parameter int PC_W = 12,
  parameter int ADDR_W = 8,
  parameter int STACK_DEPTH = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire acc_core_pkg::op_type instr_op,
  input wire logic [7:0] mem_rdata,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [7:0] imm_data,
  input wire logic [2:0] bit_sel,
  input wire logic [PC_W-1:0] target_addr,
  input wire logic irq_pending,
  input wire logic wake_req,
  input wire logic wdt_expired,
  output logic instr_ready,
  output logic [7:0] acc,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic zero_flag,
  output logic signed_wrap_flag,
  output logic signed_carry_flag,
  output logic timeout_flag,
  output logic powerdown_flag,
  output logic global_irq_enable,
  output logic [PC_W-1:0] pc,
  output logic mem_wr,
  output logic [ADDR_W-1:0] mem_waddr,
  output logic [7:0] mem_wdata,
  output logic watchdog_clear,
  output logic prescaler_clear,
  output logic clk_run,
  output logic irq_ack
);

  acc_core_pkg::state_type state_r, state_nxt;
  logic [7:0] acc_r, acc_nxt, mem_wdata_r, mem_wdata_nxt, res;
  logic [ADDR_W-1:0] mem_waddr_r;
  logic [PC_W-1:0] pc_r, pc_nxt, push_data, stack_top;
  logic c_r, c_nxt, hc_r, hc_nxt, z_r, z_nxt, sw_r, sw_nxt, scf_r, scf_nxt;
  logic to_r, to_nxt, pdf_r, pdf_nxt, gie_r, gie_nxt;
  logic wr_r, wr_nxt, wdclr_r, wdclr_nxt, psclr_r, psclr_nxt, ack_r, ack_nxt, push, pop;

  // decode of the presented operation
  wire go = instr_valid && instr_ready;
  wire [PC_W-1:0] pc_inc = PC_W'(pc_r + 1'b1);
  wire use_imm = instr_op inside {acc_core_pkg::op_sum_imm_to_acc, acc_core_pkg::op_mask_imm_to_acc,
    acc_core_pkg::op_merge_imm_to_acc, acc_core_pkg::op_copy_imm_to_acc,
    acc_core_pkg::op_sub_exit_value};
  wire use_carry = instr_op inside {acc_core_pkg::op_carry_sum_to_acc,
    acc_core_pkg::op_carry_sum_to_memory};
  wire is_add = use_carry || instr_op inside {acc_core_pkg::op_sum_to_acc,
    acc_core_pkg::op_sum_imm_to_acc, acc_core_pkg::op_sum_to_memory};
  wire sets_zero = is_add || instr_op inside {acc_core_pkg::op_mask_to_acc,
    acc_core_pkg::op_mask_imm_to_acc, acc_core_pkg::op_mask_to_memory,
    acc_core_pkg::op_merge_to_acc, acc_core_pkg::op_merge_imm_to_acc,
    acc_core_pkg::op_merge_to_memory, acc_core_pkg::op_invert_memory,
    acc_core_pkg::op_invert_to_acc, acc_core_pkg::op_count_down_memory,
    acc_core_pkg::op_count_down_to_acc, acc_core_pkg::op_count_up_memory,
    acc_core_pkg::op_count_up_to_acc};
  wire writes_mem = instr_op inside {acc_core_pkg::op_carry_sum_to_memory,
    acc_core_pkg::op_sum_to_memory, acc_core_pkg::op_mask_to_memory,
    acc_core_pkg::op_merge_to_memory, acc_core_pkg::op_zero_memory, acc_core_pkg::op_zero_bit,
    acc_core_pkg::op_invert_memory, acc_core_pkg::op_decimal_adjust,
    acc_core_pkg::op_count_down_memory, acc_core_pkg::op_count_up_memory,
    acc_core_pkg::op_copy_acc_to_memory};
  wire writes_acc = instr_op inside {acc_core_pkg::op_carry_sum_to_acc,
    acc_core_pkg::op_sum_to_acc, acc_core_pkg::op_sum_imm_to_acc, acc_core_pkg::op_mask_to_acc,
    acc_core_pkg::op_mask_imm_to_acc, acc_core_pkg::op_merge_to_acc,
    acc_core_pkg::op_merge_imm_to_acc, acc_core_pkg::op_invert_to_acc,
    acc_core_pkg::op_count_down_to_acc, acc_core_pkg::op_count_up_to_acc,
    acc_core_pkg::op_copy_operand_to_acc, acc_core_pkg::op_copy_imm_to_acc,
    acc_core_pkg::op_sub_exit_value};

  // adder shared by both sum forms; carry in only for the carry forms
  wire [7:0] opnd = use_imm ? imm_data : mem_rdata;
  wire cin = use_carry && c_r;
  wire [8:0] sum9 = {1'b0, acc_r} + {1'b0, opnd} + {8'h00, cin};
  wire [4:0] half5 = {1'b0, acc_r[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
  wire sum_wrap = (acc_r[7] == opnd[7]) && (sum9[7] != acc_r[7]);

  // decimal correction: each nibble steps by six on its own condition
  wire lo_step = (acc_r[3:0] > acc_core_pkg::BCD_LIMIT) || hc_r;
  wire hi_step = (acc_r[7:4] > acc_core_pkg::BCD_LIMIT) || c_r;
  wire [7:0] bcd_adj = {hi_step ? acc_core_pkg::BCD_STEP : acc_core_pkg::NO_STEP,
    lo_step ? acc_core_pkg::BCD_STEP : acc_core_pkg::NO_STEP};
  wire [8:0] bcd9 = {1'b0, acc_r} + {1'b0, bcd_adj};
  wire [7:0] bit_mask = ~(acc_core_pkg::ONE_BYTE << bit_sel);

  // result selection
  always_comb begin
    case (instr_op)
      acc_core_pkg::op_carry_sum_to_acc, acc_core_pkg::op_carry_sum_to_memory,
      acc_core_pkg::op_sum_to_acc, acc_core_pkg::op_sum_imm_to_acc,
      acc_core_pkg::op_sum_to_memory: res = sum9[7:0];
      acc_core_pkg::op_mask_to_acc, acc_core_pkg::op_mask_imm_to_acc,
      acc_core_pkg::op_mask_to_memory: res = acc_r & opnd;
      acc_core_pkg::op_merge_to_acc, acc_core_pkg::op_merge_imm_to_acc,
      acc_core_pkg::op_merge_to_memory: res = acc_r | opnd;
      acc_core_pkg::op_zero_memory: res = acc_core_pkg::ZERO_BYTE;
      acc_core_pkg::op_zero_bit: res = mem_rdata & bit_mask;
      acc_core_pkg::op_invert_memory, acc_core_pkg::op_invert_to_acc: res = ~mem_rdata;
      acc_core_pkg::op_decimal_adjust: res = bcd9[7:0];
      acc_core_pkg::op_count_down_memory,
      acc_core_pkg::op_count_down_to_acc: res = mem_rdata - acc_core_pkg::ONE_BYTE;
      acc_core_pkg::op_count_up_memory,
      acc_core_pkg::op_count_up_to_acc: res = mem_rdata + acc_core_pkg::ONE_BYTE;
      acc_core_pkg::op_copy_operand_to_acc, acc_core_pkg::op_copy_imm_to_acc,
      acc_core_pkg::op_sub_exit_value: res = opnd;
      default: res = acc_r;
    endcase
  end

  // sequencing, data effects and control flow
  always_comb begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    pc_nxt = pc_r;
    {c_nxt, hc_nxt, z_nxt, sw_nxt, scf_nxt} = {c_r, hc_r, z_r, sw_r, scf_r};
    {to_nxt, pdf_nxt, gie_nxt} = {to_r, pdf_r, gie_r};
    wr_nxt = 1'b0;
    mem_wdata_nxt = mem_wdata_r;
    {wdclr_nxt, psclr_nxt, ack_nxt, push, pop} = 5'b00000;
    push_data = pc_inc;
    case (state_r)
      acc_core_pkg::st_run: begin
        if (go) begin
          pc_nxt = pc_inc;
          if (writes_mem) begin
            wr_nxt = 1'b1;
            mem_wdata_nxt = res;
          end
          if (writes_acc) begin
            acc_nxt = res;
          end
          if (sets_zero) begin
            z_nxt = (res == acc_core_pkg::ZERO_BYTE);
          end
          if (is_add) begin
            {c_nxt, hc_nxt, sw_nxt, scf_nxt} =
              {sum9[8], half5 >= acc_core_pkg::HALF_LIMIT, sum_wrap, sum_wrap ^ sum9[7]};
          end
          case (instr_op)
            acc_core_pkg::op_decimal_adjust: c_nxt = c_r | bcd9[8];
            acc_core_pkg::op_sub_call: begin
              push = 1'b1;
              pc_nxt = target_addr;
              state_nxt = acc_core_pkg::st_dummy;
            end
            acc_core_pkg::op_goto_address: begin
              pc_nxt = target_addr;
              state_nxt = acc_core_pkg::st_dummy;
            end
            acc_core_pkg::op_sub_exit, acc_core_pkg::op_sub_exit_value: begin
              pop = 1'b1;
              pc_nxt = stack_top;
              state_nxt = acc_core_pkg::st_dummy;
            end
            acc_core_pkg::op_interrupt_exit: begin
              // a waiting request skips the pop and keeps the top slot as its own return address
              state_nxt = acc_core_pkg::st_dummy;
              if (irq_pending) begin
                pc_nxt = PC_W'(acc_core_pkg::IRQ_VECTOR);
                gie_nxt = 1'b0;
                ack_nxt = 1'b1;
              end else begin
                pop = 1'b1;
                pc_nxt = stack_top;
                gie_nxt = 1'b1;
              end
            end
            acc_core_pkg::op_watchdog_restart: {wdclr_nxt, to_nxt, pdf_nxt} = 3'b100;
            acc_core_pkg::op_power_down: begin
              {wdclr_nxt, psclr_nxt, to_nxt, pdf_nxt} = 4'b1101;
              state_nxt = acc_core_pkg::st_halt;
            end
            default: ;
          endcase
        end
      end
      acc_core_pkg::st_dummy: state_nxt = acc_core_pkg::st_run;
      acc_core_pkg::st_halt: begin
        if (wake_req) begin
          state_nxt = acc_core_pkg::st_run;
        end
      end
      default: state_nxt = acc_core_pkg::st_run;
    endcase
    // an expiry in the same cycle as a clear still wins
    if (wdt_expired) begin
      to_nxt = 1'b1;
    end
  end

  // architectural state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= acc_core_pkg::st_run;
      acc_r <= acc_core_pkg::ACC_RESET;
      pc_r <= PC_W'(acc_core_pkg::PC_RESET);
      {c_r, hc_r, z_r, sw_r, scf_r} <= {5{acc_core_pkg::FLAG_RESET}};
      {to_r, pdf_r} <= {2{acc_core_pkg::FLAG_RESET}};
      gie_r <= acc_core_pkg::GIE_RESET;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      pc_r <= pc_nxt;
      {c_r, hc_r, z_r, sw_r, scf_r} <= {c_nxt, hc_nxt, z_nxt, sw_nxt, scf_nxt};
      {to_r, pdf_r, gie_r} <= {to_nxt, pdf_nxt, gie_nxt};
    end
  end

  // memory write port and one-cycle strobes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {wr_r, wdclr_r, psclr_r, ack_r} <= 4'h0;
      mem_wdata_r <= acc_core_pkg::ZERO_BYTE;
      mem_waddr_r <= '0;
    end else begin
      {wr_r, wdclr_r, psclr_r, ack_r} <= {wr_nxt, wdclr_nxt, psclr_nxt, ack_nxt};
      mem_wdata_r <= mem_wdata_nxt;
      mem_waddr_r <= (go && writes_mem) ? mem_addr : mem_waddr_r;
    end
  end

  return_stack #(.DEPTH(STACK_DEPTH), .W(PC_W)) u_stack (
    .mclk(mclk),
    .rst_n(rst_n),
    .push(push),
    .pop(pop),
    .push_data(push_data),
    .top(stack_top)
  );

  // outputs; ready drops during the dummy cycle and while halted
  assign instr_ready = (state_r == acc_core_pkg::st_run);
  assign clk_run = (state_r != acc_core_pkg::st_halt);
  assign acc = acc_r;
  assign {carry_flag, half_carry_flag, zero_flag} = {c_r, hc_r, z_r};
  assign {signed_wrap_flag, signed_carry_flag} = {sw_r, scf_r};
  assign {timeout_flag, powerdown_flag, global_irq_enable} = {to_r, pdf_r, gie_r};
  assign pc = pc_r;
  assign {mem_wr, mem_waddr, mem_wdata} = {wr_r, mem_waddr_r, mem_wdata_r};
  assign {watchdog_clear, prescaler_clear, irq_ack} = {wdclr_r, psclr_r, ack_r};

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_carry_sum_acc: assert property (go && instr_op == acc_core_pkg::op_carry_sum_to_acc
    |=> acc_r == 8'($past(acc_r) + $past(mem_rdata) + {7'h00, $past(c_r)}))
    else $error("carry sum into acc wrong");
  a_sum_imm_nocarry: assert property (go && instr_op == acc_core_pkg::op_sum_imm_to_acc
    |=> acc_r == 8'($past(acc_r) + $past(imm_data)) && c_r == $past(sum9[8]))
    else $error("plain sum wrong");
  a_mask_mem_write: assert property (go && instr_op == acc_core_pkg::op_mask_to_memory
    |=> mem_wr && mem_wdata == ($past(acc_r) & $past(mem_rdata)) && $stable(c_r))
    else $error("and to memory wrong");
  a_merge_acc_zero: assert property (go && instr_op == acc_core_pkg::op_merge_imm_to_acc
    |=> acc_r == ($past(acc_r) | $past(imm_data)) && z_r == (acc_r == 8'h00) && $stable(sw_r))
    else $error("or to acc wrong");
  a_call_two_cycles: assert property (go && instr_op == acc_core_pkg::op_sub_call
    |=> pc_r == $past(target_addr) && !instr_ready && stack_top == $past(pc_inc) ##1 instr_ready)
    else $error("call sequence wrong");
  a_zero_byte: assert property (go && instr_op == acc_core_pkg::op_zero_memory
    |=> mem_wr && mem_wdata == 8'h00 && $stable(z_r))
    else $error("byte clear wrong");
  a_bit_clear: assert property (go && instr_op == acc_core_pkg::op_zero_bit
    |=> mem_wdata[$past(bit_sel)] == 1'b0
      && (mem_wdata | ~$past(bit_mask)) == ($past(mem_rdata) | ~$past(bit_mask)))
    else $error("bit clear wrong");
  a_wdt_restart: assert property (go && instr_op == acc_core_pkg::op_watchdog_restart
    && !wdt_expired |=> watchdog_clear && !timeout_flag && !powerdown_flag)
    else $error("watchdog restart wrong");
  a_invert_acc: assert property (go && instr_op == acc_core_pkg::op_invert_to_acc
    |=> acc_r == ~$past(mem_rdata) && !mem_wr)
    else $error("invert to acc wrong");
  a_bcd_carry_only: assert property (go && instr_op == acc_core_pkg::op_decimal_adjust
    |=> mem_wdata == $past(bcd9[7:0]) && $stable(z_r) && $stable(hc_r) && $stable(acc_r))
    else $error("decimal adjust wrong");
  a_count_down: assert property (go && instr_op == acc_core_pkg::op_count_down_memory
    |=> mem_wdata == 8'($past(mem_rdata) - 8'h01) && $stable(acc_r))
    else $error("decrement wrong");
  a_count_up: assert property (go && instr_op == acc_core_pkg::op_count_up_to_acc
    |=> acc_r == 8'($past(mem_rdata) + 8'h01) && !mem_wr && $stable(c_r))
    else $error("increment wrong");
  a_halt_entry: assert property (go && instr_op == acc_core_pkg::op_power_down
    && !wdt_expired |=> !clk_run && powerdown_flag && !timeout_flag && prescaler_clear)
    else $error("power down entry wrong");
  a_jump_dummy: assert property (go && instr_op == acc_core_pkg::op_goto_address
    |=> pc_r == $past(target_addr) && !instr_ready ##1 instr_ready && $stable(z_r))
    else $error("jump wrong");
  a_copy_no_flags: assert property (go && instr_op == acc_core_pkg::op_copy_acc_to_memory
    |=> mem_wdata == $past(acc_r) && $stable({c_r, z_r, hc_r, sw_r, scf_r}))
    else $error("copy wrong");
  a_idle_step: assert property (go && instr_op == acc_core_pkg::op_idle_step
    |=> pc_r == PC_W'($past(pc_r) + 1'b1) && $stable(acc_r) && !mem_wr)
    else $error("idle step wrong");
  a_exit_pops: assert property (go && instr_op == acc_core_pkg::op_sub_exit
    |=> pc_r == $past(stack_top) && !instr_ready)
    else $error("subroutine exit wrong");
  a_exit_value: assert property (go && instr_op == acc_core_pkg::op_sub_exit_value
    |=> pc_r == $past(stack_top) && acc_r == $past(imm_data) && $stable(z_r))
    else $error("exit with value wrong");
  a_irq_exit: assert property (go && instr_op == acc_core_pkg::op_interrupt_exit
    |=> (irq_ack && $past(irq_pending) && pc_r == PC_W'(acc_core_pkg::IRQ_VECTOR))
      || (global_irq_enable && !$past(irq_pending) && pc_r == $past(stack_top)))
    else $error("interrupt exit wrong");
  a_single_cycle: assert property (go && (writes_mem || writes_acc)
    && instr_op != acc_core_pkg::op_sub_exit_value |=> instr_ready)
    else $error("single-cycle op stalled");
  c_call_return: cover property (go && instr_op == acc_core_pkg::op_sub_call
    ##[2:20] go && instr_op == acc_core_pkg::op_sub_exit);
  c_irq_chain: cover property (go && instr_op == acc_core_pkg::op_interrupt_exit && irq_pending);
  c_halt_wake: cover property (!clk_run ##[1:20] clk_run);
  c_add_carry: cover property (go && is_add ##1 c_r && sw_r);
endmodule : acc_core_exec

// ### hw/acc_core_pkg.sv
// constants, opcodes and state codes shared by the accumulator execution core
package acc_core_pkg;

  // reset values and interrupt vector
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic GIE_RESET = 1'b0;
  localparam int PC_RESET = 0;
  localparam int IRQ_VECTOR = 4;

  // arithmetic constants
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_STEP = 4'h6;
  localparam logic [3:0] NO_STEP = 4'h0;
  localparam logic [4:0] HALF_LIMIT = 5'h10;

  // decoded operation presented with each instruction strobe
  typedef enum logic [4:0] {
    op_idle_step = 5'h00,
    op_carry_sum_to_acc = 5'h01,
    op_carry_sum_to_memory = 5'h02,
    op_sum_to_acc = 5'h03,
    op_sum_imm_to_acc = 5'h04,
    op_sum_to_memory = 5'h05,
    op_mask_to_acc = 5'h06,
    op_mask_imm_to_acc = 5'h07,
    op_mask_to_memory = 5'h08,
    op_merge_to_acc = 5'h09,
    op_merge_imm_to_acc = 5'h0A,
    op_merge_to_memory = 5'h0B,
    op_sub_call = 5'h0C,
    op_zero_memory = 5'h0D,
    op_zero_bit = 5'h0E,
    op_watchdog_restart = 5'h0F,
    op_invert_memory = 5'h10,
    op_invert_to_acc = 5'h11,
    op_decimal_adjust = 5'h12,
    op_count_down_memory = 5'h13,
    op_count_down_to_acc = 5'h14,
    op_power_down = 5'h15,
    op_count_up_memory = 5'h16,
    op_count_up_to_acc = 5'h17,
    op_goto_address = 5'h18,
    op_copy_operand_to_acc = 5'h19,
    op_copy_imm_to_acc = 5'h1A,
    op_copy_acc_to_memory = 5'h1B,
    op_sub_exit = 5'h1C,
    op_sub_exit_value = 5'h1D,
    op_interrupt_exit = 5'h1E
  } op_type;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    st_run = 3'b001,
    st_dummy = 3'b010,
    st_halt = 3'b100
  } state_type;

endpackage : acc_core_pkg

// ### hw/return_stack.sv
// circular return-address stack for the execution core
module return_stack #(
  parameter int DEPTH = 8,
  parameter int W = 12
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] push_data,
  output logic [W-1:0] top
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] slot [DEPTH];
  logic [AW-1:0] sp_r;
  wire [AW-1:0] sp_top = AW'(sp_r - 1'b1);

  // overflow wraps silently, as a fixed-depth hardware stack does
  assign top = slot[sp_top];

  // pointer to the next free slot
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sp_r <= '0;
    end else if (push && !pop) begin
      sp_r <= AW'(sp_r + 1'b1);
    end else if (pop && !push) begin
      sp_r <= sp_top;
    end
  end

  // storage is not reset; a push and pop together replaces the top
  always_ff @(posedge mclk) begin
    if (push && !pop) begin
      slot[sp_r] <= push_data;
    end else if (push && pop) begin
      slot[sp_top] <= push_data;
    end
  end

endmodule : return_stack

// ### testbench/accumulator_core_instruction_semantics_tb.sv
// self-checking random bench for the accumulator execution core
module accumulator_core_instruction_semantics_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
  logic mclk, rst_n, instr_valid, irq_pending, wake_req, wdt_expired;
  acc_core_pkg::op_type instr_op;
  logic [7:0] mem_rdata, imm_data, acc, mem_wdata, mem_waddr, mem_addr;
  logic [2:0] bit_sel;
  logic [11:0] target_addr, pc, m_pc;
  logic instr_ready, cf, hf, zf, of, sf, tf, pf, gf, mem_wr, wdc, psc, clk_run, irq_ack;
  logic m_c, m_ac, m_z, m_ov, m_sc, m_to, m_pdf, m_gie;
  logic [7:0] m_acc;
  logic [7:0] mem [256];
  logic [11:0] stk [$];
  logic [31:0] seed;
  int mismatches, check_count, o;
  wire [7:0] flags_seen = {cf, hf, zf, of, sf, tf, pf, gf};
  wire [7:0] flags_exp = {m_c, m_ac, m_z, m_ov, m_sc, m_to, m_pdf, m_gie};
  wire [3:0] pulses_seen = {wdc, psc, clk_run, irq_ack};

  acc_core_exec dut_u (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_op(instr_op), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .imm_data(imm_data),
    .bit_sel(bit_sel), .target_addr(target_addr), .irq_pending(irq_pending),
    .wake_req(wake_req), .wdt_expired(wdt_expired), .instr_ready(instr_ready), .acc(acc),
    .carry_flag(cf), .half_carry_flag(hf), .zero_flag(zf), .signed_wrap_flag(of),
    .signed_carry_flag(sf), .timeout_flag(tf), .powerdown_flag(pf), .global_irq_enable(gf),
    .pc(pc), .mem_wr(mem_wr), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
    .watchdog_clear(wdc), .prescaler_clear(psc), .clk_run(clk_run), .irq_ack(irq_ack));

  // 25 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // flags {c, half, z, wrap, signed carry} above the 8-bit sum
  function automatic logic [12:0] add_f(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic ov;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    ov = (a[7] == b[7]) && (s[7] != a[7]);
    return {s[8], ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci}) > 5'h0F, s[7:0] == 8'h00,
      ov, ov ^ s[7], s[7:0]};
  endfunction : add_f

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // one instruction: drive, wait for the take, then compare against the bench model
  task automatic run_op(input int op);
    logic [7:0] m, src, res, ad;
    logic [12:0] r;
    logic [8:0] d;
    logic wr, ta, zu, two, rdy, ack, ex;
    seed = xs(seed);
    ex = seed[5] & seed[13];
    ad = seed[7:0];
    m = mem[ad];
    src = (op inside {4, 7, 10, 26, 29}) ? seed[15:8] : m;
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_op <= acc_core_pkg::op_type'(op[4:0]);
    mem_addr <= ad;
    mem_rdata <= m;
    imm_data <= seed[15:8];
    bit_sel <= seed[18:16];
    target_addr <= seed[30:19];
    irq_pending <= seed[31];
    wdt_expired <= ex;
    for (int k = 0; k <= 40; k++) begin
      @(negedge mclk);
      rdy = instr_ready;
      @(posedge mclk);
      if (rdy === 1'b1) break;
      if (k == 40) begin
        mismatches++;
        final_report();
      end
    end
    instr_valid <= 1'b0;
    wdt_expired <= 1'b0;
    res = m;
    ack = 1'b0;
    m_pc = m_pc + 12'h001;
    case (op)
      1, 2, 3, 4, 5: begin
        r = add_f(m_acc, src, (op <= 2) ? m_c : 1'b0);
        {m_c, m_ac, m_z, m_ov, m_sc} = r[12:8];
        res = r[7:0];
      end
      6, 7, 8: res = m_acc & src;
      9, 10, 11: res = m_acc | src;
      12: begin
        stk.push_back(m_pc);
        m_pc = seed[30:19];
      end
      13: res = 8'h00;
      14: res = m & ~(8'h01 << seed[18:16]);
      15: {m_to, m_pdf} = 2'b00;
      16, 17: res = ~m;
      18: begin
        // nibble tests look at the accumulator before correction
        d = {1'b0, m_acc} + {1'b0, (m_acc[7:4] > 4'h9 || m_c) ? 4'h6 : 4'h0,
          (m_acc[3:0] > 4'h9 || m_ac) ? 4'h6 : 4'h0};
        m_c = m_c | d[8];
        res = d[7:0];
      end
      19, 20: res = m - 8'h01;
      21: {m_to, m_pdf} = 2'b01;
      22, 23: res = m + 8'h01;
      24: m_pc = seed[30:19];
      25, 26, 29: res = src;
      27: res = m_acc;
      default: ;
    endcase
    if (op == 28 || op == 29 || (op == 30 && !seed[31])) m_pc = stk.pop_back();
    if (op == 30 && seed[31]) m_pc = 12'(acc_core_pkg::IRQ_VECTOR);
    if (op == 30) {m_gie, ack} = seed[31] ? 2'b01 : 2'b10;
    // an expiry seen with the instruction beats any clear of the timeout flag
    if (ex) m_to = 1'b1;
    wr = op inside {2, 5, 8, 11, 13, 14, 16, 18, 19, 22, 27};
    ta = op inside {1, 3, 4, 6, 7, 9, 10, 17, 20, 23, 25, 26, 29};
    zu = op inside {[6:11], 16, 17, 19, 20, 22, 23};
    two = op inside {12, 24, 28, 29, 30};
    if (ta) m_acc = res;
    if (zu) m_z = (res == 8'h00);
    #1;
    `CHK("acc", m_acc, acc)
    `CHK("flags", flags_exp, flags_seen)
    `CHK("pc", m_pc, pc)
    `CHK("write", wr, mem_wr)
    if (wr) `CHK("wdata", {ad, res}, {mem_waddr, mem_wdata})
    `CHK("ready", !(two || op == 21), instr_ready)
    `CHK("pulses", {op == 15 || op == 21, op == 21, op != 21, ack}, pulses_seen)
    if (wr) mem[ad] = res;
    // power-down stays halted until the wake request is seen
    if (op == 21) begin
      repeat (3) @(negedge mclk);
      `CHK("halt", 2'b00, {instr_ready, clk_run})
      @(posedge mclk);
      wake_req <= 1'b1;
      @(posedge mclk);
      wake_req <= 1'b0;
    end
  endtask : run_op

  initial begin
    seed = 32'h0000E0E6;
    {rst_n, instr_valid, irq_pending, wake_req, wdt_expired} = 5'h00;
    instr_op = acc_core_pkg::op_idle_step;
    {mem_rdata, imm_data, mem_addr, bit_sel, target_addr} = 39'h0;
    {m_c, m_ac, m_z, m_ov, m_sc, m_to, m_pdf, m_gie} = 8'h00;
    m_acc = 8'h00;
    m_pc = 12'h000;
    for (int i = 0; i < 256; i++) begin
      seed = xs(seed);
      mem[i] = seed[7:0];
    end
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    `CHK("reset", 28'h0000000, {acc, pc, cf, hf, zf, of, sf, tf, pf, gf})
    // every opcode once; exits get a call first so the stack is never empty
    for (o = 0; o <= 30; o++) begin
      if (o >= 28) run_op(12);
      run_op(o);
    end
    $display("test all_opcodes done");
    // decimal adjust after loads and sums of random bytes
    for (int i = 0; i < 20; i++) begin
      run_op(26);
      run_op(4);
      run_op(18);
    end
    $display("test decimal_adjust done");
    for (int i = 0; i < 400; i++) begin
      o = int'(seed % 31);
      if (o >= 28 && stk.size() == 0) o = 12;
      if (o == 12 && stk.size() >= 8) o = 28;
      run_op(o);
    end
    $display("test random_stream done");
    // reset in mid-run: registers and the stack pointer return to their reset values
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    {m_c, m_ac, m_z, m_ov, m_sc, m_to, m_pdf, m_gie, m_acc, m_pc} = 28'h0000000;
    stk.delete();
    @(negedge mclk);
    `CHK("mid_reset", 28'h0000000, {acc, pc, flags_seen})
    for (int i = 0; i < 20; i++) begin
      run_op(int'(seed % 28));
    end
    $display("test mid_reset done");
    final_report();
  end
endmodule : accumulator_core_instruction_semantics_tb
